// ==== tmr_cfg_pkg.sv ====
// constants for the timer configuration and clock-source block
`default_nettype none
package tmr_cfg_pkg;
    // ********************************************************************
    // register map
    // ********************************************************************
    localparam logic [11:0] CFG_OFFSET      = 12'h000;
    localparam logic [11:0] MATCH_L_OFFSET  = 12'h004;
    localparam logic [11:0] MATCH_H_OFFSET  = 12'h008;
    localparam logic [11:0] RELOAD_L_OFFSET = 12'h00c;
    localparam logic [11:0] RELOAD_H_OFFSET = 12'h010;
    localparam logic [11:0] COUNT_OFFSET    = 12'h014;
    localparam logic [11:0] RELOAD_CMD_OFFSET = 12'h018;
    // ********************************************************************
    // configuration fields
    // ********************************************************************
    localparam int MERGE_BIT      = 0;
    localparam int MODE_LSB       = 1;
    localparam int MODE_MSB       = 2;
    localparam int SEL_LSB        = 3;
    localparam int SEL_MSB        = 6;
    localparam int INHIBIT_L_BIT  = 7;
    localparam int INHIBIT_H_BIT  = 8;
    localparam logic [8:0]  CFG_RESET      = 9'h000;
    localparam logic [15:0] HALF_RESET     = 16'h0000;
    localparam int NUM_INPUTS = 8;
    localparam int SYNC_STAGES = 3;
    // ********************************************************************
    // clock modes
    // ********************************************************************
    typedef enum logic [1:0] {
        MODE_SYSCLK      = 2'h0,
        MODE_PRESCALED   = 2'h1,
        MODE_INPUT       = 2'h2,
        MODE_PRESC_INPUT = 2'h3
    } clock_source_mode_type;
endpackage : tmr_cfg_pkg
`default_nettype wire

// ==== tmr_input_sync.sv ====
// three-stage synchroniser with edge detection for the timer inputs
`default_nettype none
module tmr_input_sync (
    // clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_rstn,
    // asynchronous inputs
    input  wire logic [tmr_cfg_pkg::NUM_INPUTS-1:0]  i_pins,
    // synchronised level and edges
    output logic      [tmr_cfg_pkg::NUM_INPUTS-1:0]  o_level,
    output logic      [tmr_cfg_pkg::NUM_INPUTS-1:0]  o_rise,
    output logic      [tmr_cfg_pkg::NUM_INPUTS-1:0]  o_fall
);
    logic [tmr_cfg_pkg::NUM_INPUTS-1:0] s1_q;
    logic [tmr_cfg_pkg::NUM_INPUTS-1:0] s2_q;
    logic [tmr_cfg_pkg::NUM_INPUTS-1:0] s3_q;
    logic [tmr_cfg_pkg::NUM_INPUTS-1:0] level_q;

    genvar g;
    generate
        for (g = 0; g < tmr_cfg_pkg::NUM_INPUTS; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    s1_q[g]    <= 1'b0;
                    s2_q[g]    <= 1'b0;
                    s3_q[g]    <= 1'b0;
                    level_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= i_pins[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // change counts once stages two and three agree
                    if (s2_q[g] == s3_q[g]) begin
                        level_q[g] <= s3_q[g];
                    end
                end
            end
            assign o_rise[g] = (s2_q[g] == s3_q[g]) && s3_q[g] && !level_q[g];
            assign o_fall[g] = (s2_q[g] == s3_q[g]) && !s3_q[g] && level_q[g];
        end
    endgenerate
    assign o_level = level_q;
endmodule // tmr_input_sync
`default_nettype wire

// ==== tmr_clock_select.sv ====
// timer configuration register, clock-source selection and match reload
`default_nettype none
module tmr_clock_select (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // register port
    input  wire logic [11:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // timer inputs
    input  wire logic [7:0]  i_timer_in,
    // reload request from the counter logic
    input  wire logic        i_reload_l,
    input  wire logic        i_reload_h,
    // timer-facing status
    output logic             o_tick,
    output logic             o_presc_en,
    output logic             o_merged,
    output logic      [31:0] o_match,
    output logic      [31:0] o_count
);
    // ********************************************************************
    // register decode
    // ********************************************************************
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    logic [8:0]  cfg_q;
    logic [15:0] match_l_q;
    logic [15:0] match_h_q;
    logic [15:0] reload_l_q;
    logic [15:0] reload_h_q;
    logic [31:0] count_q;
    logic [31:0] rdata_q;
    logic        sw_reload_q;

    logic [3:0]  sel;
    logic [1:0]  mode_bits;
    logic        merged;
    logic        inh_l;
    logic        inh_h;
    assign sel       = cfg_q[tmr_cfg_pkg::SEL_MSB:tmr_cfg_pkg::SEL_LSB];
    assign mode_bits = cfg_q[tmr_cfg_pkg::MODE_MSB:tmr_cfg_pkg::MODE_LSB];
    assign merged    = cfg_q[tmr_cfg_pkg::MERGE_BIT];
    assign inh_l     = cfg_q[tmr_cfg_pkg::INHIBIT_L_BIT];
    assign inh_h     = cfg_q[tmr_cfg_pkg::INHIBIT_H_BIT];

    // ********************************************************************
    // configuration register
    // ********************************************************************
    // select field resets
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q <= tmr_cfg_pkg::CFG_RESET;
        end else if (i_wr && hit(i_addr, tmr_cfg_pkg::CFG_OFFSET)) begin
            cfg_q <= i_wdata[8:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            reload_l_q <= tmr_cfg_pkg::HALF_RESET;
            reload_h_q <= tmr_cfg_pkg::HALF_RESET;
        end else if (i_wr) begin
            if (hit(i_addr, tmr_cfg_pkg::RELOAD_L_OFFSET)) begin
                reload_l_q <= i_wdata[15:0];
            end
            if (hit(i_addr, tmr_cfg_pkg::RELOAD_H_OFFSET)) begin
                reload_h_q <= i_wdata[15:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sw_reload_q <= 1'b0;
        end else begin
            sw_reload_q <= i_wr && hit(i_addr, tmr_cfg_pkg::RELOAD_CMD_OFFSET) && i_wdata[0];
        end
    end

    // ********************************************************************
    // clock source
    // ********************************************************************
    logic [7:0] lvl;
    logic [7:0] rise;
    logic [7:0] fall;

    tmr_input_sync u_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_pins  (i_timer_in),
        .o_level (lvl),
        .o_rise  (rise),
        .o_fall  (fall)
    );

    logic [2:0] in_idx;
    logic       edge_seen;
    assign in_idx    = sel[3:1];
    assign edge_seen = sel[0] ? fall[in_idx] : rise[in_idx];

    tmr_cfg_pkg::clock_source_mode_type mode;
    assign mode = tmr_cfg_pkg::clock_source_mode_type'(mode_bits);

    always_comb begin
        o_tick     = 1'b1;
        o_presc_en = 1'b1;
        case (mode)
            tmr_cfg_pkg::MODE_SYSCLK: begin
                o_tick     = 1'b1;
                o_presc_en = 1'b1;
            end
            tmr_cfg_pkg::MODE_PRESCALED: begin
                o_tick     = 1'b1;
                o_presc_en = edge_seen;
            end
            tmr_cfg_pkg::MODE_INPUT, tmr_cfg_pkg::MODE_PRESC_INPUT: begin
                o_tick     = edge_seen;
                o_presc_en = edge_seen;
            end
            default: begin
                o_tick     = 1'b1;
                o_presc_en = 1'b1;
            end
        endcase
    end

    // ********************************************************************
    // counter width and match reload
    // ********************************************************************
    logic do_l;
    logic do_h;
    assign do_l = (i_reload_l || sw_reload_q) && !inh_l;
    assign do_h = merged ? ((i_reload_l || sw_reload_q) && !inh_l)
                         : ((i_reload_h || sw_reload_q) && !inh_h);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            match_l_q <= tmr_cfg_pkg::HALF_RESET;
            match_h_q <= tmr_cfg_pkg::HALF_RESET;
        end else begin
            if (i_wr && hit(i_addr, tmr_cfg_pkg::MATCH_L_OFFSET)) begin
                match_l_q <= i_wdata[15:0];
            end else if (do_l) begin
                match_l_q <= reload_l_q;
            end
            if (i_wr && hit(i_addr, tmr_cfg_pkg::MATCH_H_OFFSET)) begin
                match_h_q <= i_wdata[15:0];
            end else if (do_h) begin
                match_h_q <= reload_h_q;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_q <= 32'h0000_0000;
        end else if (o_tick) begin
            if (merged) begin
                count_q <= count_q + 32'h0000_0001;
            end else begin
                count_q <= {count_q[31:16] + 16'h0001, count_q[15:0] + 16'h0001};
            end
        end
    end

    // ********************************************************************
    // read port
    // ********************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_rd) begin
            if (hit(i_addr, tmr_cfg_pkg::CFG_OFFSET)) begin
                rdata_q <= {23'h000000, cfg_q};
            end else if (hit(i_addr, tmr_cfg_pkg::MATCH_L_OFFSET)) begin
                rdata_q <= {16'h0000, match_l_q};
            end else if (hit(i_addr, tmr_cfg_pkg::MATCH_H_OFFSET)) begin
                rdata_q <= {16'h0000, match_h_q};
            end else if (hit(i_addr, tmr_cfg_pkg::RELOAD_L_OFFSET)) begin
                rdata_q <= {16'h0000, reload_l_q};
            end else if (hit(i_addr, tmr_cfg_pkg::RELOAD_H_OFFSET)) begin
                rdata_q <= {16'h0000, reload_h_q};
            end else if (hit(i_addr, tmr_cfg_pkg::COUNT_OFFSET)) begin
                rdata_q <= count_q;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign o_rdata  = rdata_q;
    assign o_merged = merged;
    assign o_match  = {match_h_q, match_l_q};
    assign o_count  = count_q;
endmodule // tmr_clock_select
`default_nettype wire

// ==== tmr_clock_select_chk.sv ====
// checker for the timer clock-select block
`default_nettype none
module tmr_clock_select_chk (
    // clock, reset and register port
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // timer side
    input wire logic [7:0]  i_timer_in,
    input wire logic        i_reload_l,
    input wire logic        o_tick,
    input wire logic        o_presc_en,
    input wire logic        o_merged,
    input wire logic [31:0] o_match,
    input wire logic [31:0] o_count
);
    // ****************************************
    // shadow of written registers
    // ****************************************
    logic [8:0]  cfg_q;
    logic [15:0] rl_q;
    logic [15:0] rh_q;
    logic        sel_in;
    assign sel_in = i_timer_in[cfg_q[6:4]];
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q <= 9'h000;
            rl_q  <= 16'h0000;
            rh_q  <= 16'h0000;
        end else if (i_wr) begin
            if (i_addr == 12'h000) cfg_q <= i_wdata[8:0];
            if (i_addr == 12'h00c) rl_q <= i_wdata[15:0];
            if (i_addr == 12'h010) rh_q <= i_wdata[15:0];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence sel_edge;
        cfg_q[2] && $stable(cfg_q) && (cfg_q[3] ? $fell(sel_in) : $rose(sel_in));
    endsequence
    sequence quiet_reload;
        i_reload_l && !i_wr && !$past(i_wr);
    endsequence
    chk_cfg_read: assert property (i_rd && i_addr == 12'h000 |=> o_rdata == {23'h0, $past(cfg_q)})
        else $error("configuration readback wrong");
    chk_merge_out: assert property (i_wr && i_addr == 12'h000 |=> o_merged == $past(i_wdata[0]))
        else $error("merge output wrong");
    chk_sys_tick: assert property (cfg_q[2:1] == 2'h0 |-> o_tick && o_presc_en)
        else $error("system clock mode not ticking");
    chk_edge_tick: assert property (sel_edge |-> ##[1:4] o_tick)
        else $error("selected edge gave no tick");
    chk_quiet_tick: assert property ((cfg_q[2] && $stable(cfg_q) && $stable(sel_in))[*8] |-> !o_tick)
        else $error("tick without input edge");
    chk_low_reload: assert property (quiet_reload ##0 !cfg_q[7] |=> o_match[15:0] == $past(rl_q))
        else $error("low match not reloaded");
    chk_low_inhibit: assert property (quiet_reload ##0 cfg_q[7] |=> $stable(o_match[15:0]))
        else $error("inhibited low match changed");
    chk_merge_both: assert property (quiet_reload ##0 o_merged |=>
        o_match[31:16] == ($past(cfg_q[7]) ? $past(o_match[31:16]) : $past(rh_q)))
        else $error("merged high match wrong");
    chk_count_step: assert property (o_merged && o_tick |=> o_count == $past(o_count) + 32'h1)
        else $error("merged count step wrong");
endmodule // tmr_clock_select_chk
bind tmr_clock_select tmr_clock_select_chk chk_i (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .i_timer_in (i_timer_in),
    .i_reload_l (i_reload_l),
    .o_tick     (o_tick),
    .o_presc_en (o_presc_en),
    .o_merged   (o_merged),
    .o_match    (o_match),
    .o_count    (o_count)
);
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the timer clock-select block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rstn, i_wr, i_rd, i_reload_l, i_reload_h;
    logic        o_tick, o_presc_en, o_merged;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata, o_match, o_count;
    logic [7:0]  i_timer_in, pins;
    int          n_fail, num_checks, ml, mh, rl, rh, cfg, hits, pres, m;
    logic [31:0] c0, cexp;

    tmr_clock_select uut (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_addr     (i_addr),
        .i_wdata    (i_wdata),
        .i_wr       (i_wr),
        .i_rd       (i_rd),
        .o_rdata    (o_rdata),
        .i_timer_in (i_timer_in),
        .i_reload_l (i_reload_l),
        .i_reload_h (i_reload_h),
        .o_tick     (o_tick),
        .o_presc_en (o_presc_en),
        .o_merged   (o_merged),
        .o_match    (o_match),
        .o_count    (o_count)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(what, exp, o_rdata);
    endtask
    // drive inputs, then count ticks over a fixed window
    task automatic drive_count(input logic [7:0] p);
        @(posedge i_clk);
        i_timer_in <= p;
        hits = 0;
        pres = 0;
        repeat (8) begin
            @(posedge i_clk);
            #1;
            if (o_tick === 1'b1) hits++;
            if (o_presc_en === 1'b1) pres++;
        end
    endtask

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #500us;
        n_fail++;
        close_out();
    end
    initial begin
        {i_rstn, i_wr, i_rd, i_reload_l, i_reload_h} = 5'h00;
        i_addr = 12'h000;
        i_wdata = 32'h0;
        i_timer_in = 8'h00;
        void'($urandom(32'hbaaa));
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(12'h000, 32'h0, "cfg reset");
        check("match reset", 32'h0, o_match);
        rd(12'h0fc, 32'h0, "unmapped read");
        $display("reset test done");
        for (int s = 0; s < 16; s++) begin
            // modes 1, 2 and 3 in turn
            m = 1 + (s % 3);
            pins = 8'($urandom);
            pins[s >> 1] = ~s[0];
            wr(12'h000, 32'(s << 3) | 32'(m << 1));
            drive_count(pins);
            pins[s >> 1] = s[0];
            drive_count(pins);
            check("wrong edge ticks", (m == 1) ? 32'h8 : 32'h0, 32'(hits));
            check("wrong edge prescale", 32'h0, 32'(pres));
            pins[s >> 1] = ~s[0];
            drive_count(pins);
            check("right edge ticks", (m == 1) ? 32'h8 : 32'h1, 32'(hits));
            check("right edge prescale", 32'h1, 32'(pres));
        end
        wr(12'h000, 32'h78);
        drive_count(8'($urandom));
        check("system clock ticks", 32'h8, 32'(hits));
        check("system clock prescale", 32'h8, 32'(pres));
        $display("clock select test done");
        for (int k = 0; k < 4; k++) begin
            cfg = (k[1] << 7) | k[0];
            rl = $urandom & 16'hffff;
            rh = $urandom & 16'hffff;
            wr(12'h000, cfg);
            rd(12'h000, cfg, "cfg readback");
            wr(12'h00c, rl);
            wr(12'h010, rh);
            @(posedge i_clk);
            i_reload_l <= 1'b1;
            i_reload_h <= ~k[0];
            @(posedge i_clk);
            i_reload_l <= 1'b0;
            i_reload_h <= 1'b0;
            #1;
            if (!k[1]) ml = rl;
            if (!k[1] || !k[0]) mh = rh;
            check("match", {mh[15:0], ml[15:0]}, o_match);
            c0 = o_count;
            repeat (5) @(posedge i_clk);
            #1;
            cexp = k[0] ? c0 + 32'h5 : {c0[31:16] + 16'h0005, c0[15:0] + 16'h0005};
            check("count step", cexp, o_count);
        end
        $display("reload test done");
        // dual halves, high inhibited, software reload command
        wr(12'h000, 32'h100);
        rl = $urandom & 16'hffff;
        rh = $urandom & 16'hffff;
        wr(12'h00c, rl);
        wr(12'h010, rh);
        wr(12'h018, 32'h1);
        @(posedge i_clk);
        #1;
        ml = rl;
        check("software reload", {mh[15:0], ml[15:0]}, o_match);
        $display("software reload test done");
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        ml = 0;
        mh = 0;
        rd(12'h000, 32'h0, "cfg after reset");
        check("match after reset", {mh[15:0], ml[15:0]}, o_match);
        $display("mid-run reset test done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
